// ---- core/rbf_pkg.sv ----
package rbf_pkg;
  // link codes and crc
  localparam logic [31:0] SOP_CODE     = 32'h1e5a_c3b7;
  localparam logic [31:0] PN_CODE      = 32'h9b3c_26d1;
  localparam logic [15:0] CRC_POLY     = 16'h8005;
  localparam logic [15:0] CRC_SEED_RST = 16'h0000;
  // channel range and reset value
  localparam logic [6:0]  CHAN_CNT     = 7'h62;
  localparam logic [6:0]  CHAN_RST     = 7'h00;
  // chip counts minus one: sop pair, gfsk byte, dsss byte
  localparam logic [6:0]  CNT_SOP      = 7'h3f;
  localparam logic [6:0]  CNT_GFSK     = 7'h07;
  localparam logic [6:0]  CNT_DSSS     = 7'h1f;

  typedef enum logic [2:0] {TX_IDLE = 3'h1, TX_SOP = 3'h2, TX_BODY = 3'h4} rbf_tx_t;
  typedef enum logic [1:0] {RX_HUNT = 2'h1, RX_BODY = 2'h2} rbf_rx_t;

  // usb crc16, msb first, one byte
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ({r[14:0], 1'h0} ^ CRC_POLY) : {r[14:0], 1'h0};
    end
    return r;
  endfunction

  // one byte into one 32-chip symbol, four chips per bit
  function automatic logic [31:0] spread(input logic [7:0] b);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      r[i] = PN_CODE[i] ^ b[i / 4];
    end
    return r;
  endfunction

  // two-of-four vote of despread chips per bit, a 2-2 tie gives one
  function automatic logic [7:0] despread(input logic [31:0] c);
    logic [7:0] r;
    logic [2:0] s;
    r = 8'h0;
    for (int j = 0; j < 8; j++) begin
      s = 3'h0;
      for (int k = 0; k < 4; k++) begin
        s = s + {2'h0, c[4 * j + k] ^ PN_CODE[4 * j + k]};
      end
      r[j] = (s >= 3'h2);
    end
    return r;
  endfunction
endpackage

// ---- core/rbf_framer.sv ----
// How it works
// R01: gfsk sends one bit per link clock
// R02: dsss packs one byte per 32-chip symbol
// R03: mode covers length, payload and crc
// R04: receiver learns rate from sop pair
// R05: valid packet triggers automatic ack packet
// R06: spreading, sop/eop detection, crc generate/check
// R07: channel number limited to 98 channels
// R08: pn codes are 32 chips long
// R09: data and configuration come from spi master
// R10: external party pulses reset after power-up
// R11: irq pin polarity select or gpio
// R12: miso carries data in four-wire mode
// R13: clock pin drives clock or gpio
// R14: packet starts with two-symbol sop marker
// R15: first byte after sop is length
// R16: eop after length plus two crc bytes
// R17: usb crc16 with programmable seed
// R18: mode, framing, auto ack are config bits
`timescale 1ns/10ps

// ****************************************
// byte fifo
// ****************************************
module rbf_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // fill side
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  // drain side
  output logic [W-1:0]      out_data_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;

  // extra pointer bit tells full from empty
  assign in_ready_out  = (wp_reg[AW] == rp_reg[AW]) || (wp_reg[AW-1:0] != rp_reg[AW-1:0]);
  assign out_valid_out = (wp_reg != rp_reg);
  assign out_data_out  = mem_reg[rp_reg[AW-1:0]];

  // write port
  always_ff @(posedge clk_in) begin
    if (in_valid_in && in_ready_out) begin
      mem_reg[wp_reg[AW-1:0]] <= in_data_in;
    end
  end

  // pointers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid_in && in_ready_out) wp_reg <= wp_reg + 1'h1;
      if (out_valid_out && out_ready_in) rp_reg <= rp_reg + 1'h1;
    end
  end
endmodule // rbf_fifo

// ****************************************
// framer top
// ****************************************
module rbf_framer #(
  parameter int unsigned FIFO_D = 16
) (
  // clocks and reset
  input  wire logic       clk_sys_in,
  input  wire logic       clk_link_in,
  input  wire logic       reset_in,
  // configuration
  input  wire logic       mode_dsss_in,
  input  wire logic       framing_en_in,
  input  wire logic       auto_ack_en_in,
  input  wire logic [15:0] crc_seed_in,
  input  wire logic       crc_zero_seed_in,
  input  wire logic [6:0] chan_in,
  output logic [6:0]      chan_out,
  // transmit
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  input  wire logic [7:0] tx_len_in,
  input  wire logic       tx_go_in,
  output logic            tx_busy_out,
  output logic            tx_done_out,
  // receive
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_done_out,
  output logic            rx_crc_ok_out,
  output logic [7:0]      rx_len_out,
  // link
  input  wire logic       link_rx_in,
  output logic            link_tx_out,
  output logic            link_tx_en_out,
  // pins: 0 irq, 1 miso, 2 buffered_clock_out_pin
  input  wire logic       irq_event_in,
  input  wire logic       irq_low_in,
  input  wire logic       irq_gpio_in,
  input  wire logic       spi_4wire_in,
  input  wire logic       miso_data_in,
  input  wire logic       radio_port_select_n_in,
  input  wire logic       clk_out_gpio_in,
  input  wire logic [2:0] gpio_out_in,
  input  wire logic [2:0] gpio_oe_in,
  input  wire logic [2:0] pin_in,
  output logic [2:0]      pin_out,
  output logic [2:0]      pin_oe_out,
  output logic [2:0]      gpio_in_out
);
  // ****************************************
  // system clock side
  // ****************************************
  logic [7:0]  go_len_reg, hd_data_reg, fifo_data;
  logic [15:0] go_seed_reg;
  logic        go_mode_reg, go_tog_reg, ack_tog_reg, want_reg, fifo_valid;
  logic [2:0]  req_s_reg, rxt_s_reg, rdn_s_reg, txd_s_reg;
  logic [1:0]  sel_s_reg;
  logic [2:0]  pin_s1_reg, pin_s2_reg, pin_d, oe_d;
  logic        clk_div_reg;
  // link side, read across only through handshakes
  logic        req_tog_reg, rx_tog_reg, rdn_tog_reg, txd_tog_reg, rx_ok_reg;
  logic [7:0]  rx_byte_reg, rx_len_reg;

  rbf_fifo #(.W(8), .D(FIFO_D)) u_fifo (
    .clk_in        (clk_sys_in),
    .rst_in        (reset_in),
    .in_data_in    (tx_data_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (want_reg)
  );

  // toggle synchronisers from the link side, plus port select and pin level synchronisers; bit 0 only feeds bit 1
  always_ff @(posedge clk_sys_in) begin
    req_s_reg  <= {req_s_reg[1:0], req_tog_reg};
    rxt_s_reg  <= {rxt_s_reg[1:0], rx_tog_reg};
    rdn_s_reg  <= {rdn_s_reg[1:0], rdn_tog_reg};
    txd_s_reg  <= {txd_s_reg[1:0], txd_tog_reg};
    sel_s_reg  <= {sel_s_reg[0], radio_port_select_n_in};
    pin_s1_reg <= pin_in;
    pin_s2_reg <= pin_s1_reg;
  end

  // go bundle stays frozen while busy, so the link may sample it
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      go_len_reg  <= 8'h0;
      go_seed_reg <= rbf_pkg::CRC_SEED_RST;
      go_mode_reg <= 1'h0;
      go_tog_reg  <= 1'h0;
      tx_busy_out <= 1'h0;
    end else if (tx_go_in && !tx_busy_out) begin
      go_len_reg  <= tx_len_in;
      go_seed_reg <= crc_zero_seed_in ? 16'h0 : crc_seed_in; // R17
      go_mode_reg <= mode_dsss_in; // R18
      go_tog_reg  <= ~go_tog_reg;
      tx_busy_out <= 1'h1;
    end else if (txd_s_reg[2] != txd_s_reg[1]) begin
      tx_busy_out <= 1'h0;
    end
  end

  // payload byte requests: pop only when the link asked, then acknowledge
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      want_reg    <= 1'h0;
      ack_tog_reg <= 1'h0;
      hd_data_reg <= 8'h0;
    end else if (want_reg && fifo_valid) begin
      want_reg    <= 1'h0;
      hd_data_reg <= fifo_data; // R09
      ack_tog_reg <= ~ack_tog_reg;
    end else if (req_s_reg[2] != req_s_reg[1]) begin
      want_reg <= 1'h1;
    end
  end

  // receive results into the system domain
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_data_out   <= 8'h0;
      rx_valid_out  <= 1'h0;
      rx_done_out   <= 1'h0;
      rx_crc_ok_out <= 1'h0;
      rx_len_out    <= 8'h0;
      tx_done_out   <= 1'h0;
    end else begin
      rx_valid_out <= (rxt_s_reg[2] != rxt_s_reg[1]);
      rx_done_out  <= (rdn_s_reg[2] != rdn_s_reg[1]);
      tx_done_out  <= (txd_s_reg[2] != txd_s_reg[1]);
      if (rxt_s_reg[2] != rxt_s_reg[1]) rx_data_out <= rx_byte_reg;
      if (rdn_s_reg[2] != rdn_s_reg[1]) begin
        rx_crc_ok_out <= rx_ok_reg;
        rx_len_out    <= rx_len_reg;
      end
    end
  end

  // channel: out-of-range requests are ignored
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      chan_out <= rbf_pkg::CHAN_RST;
    end else if (chan_in < rbf_pkg::CHAN_CNT) begin
      chan_out <= chan_in; // R07
    end
  end

  // buffered clock copy at half rate; a flop keeps glitches off the pin
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) clk_div_reg <= 1'h0;
    else clk_div_reg <= ~clk_div_reg;
  end

  // pin function or gpio, per pin
  for (genvar g = 0; g < 3; g++) begin : g_pin
    logic fn_gpio, fn_val, fn_oe;
    assign fn_gpio  = (g == 0) ? irq_gpio_in : (g == 1) ? !spi_4wire_in : clk_out_gpio_in;
    assign fn_val   = (g == 0) ? (irq_event_in ^ irq_low_in) // R11
                    : (g == 1) ? miso_data_in : clk_div_reg; // R12 R13
    assign fn_oe    = (g == 1) ? !sel_s_reg[1] : 1'h1;
    assign pin_d[g] = fn_gpio ? gpio_out_in[g] : fn_val;
    assign oe_d[g]  = fn_gpio ? gpio_oe_in[g] : fn_oe;
  end

  // pin drivers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pin_out     <= 3'h0;
      pin_oe_out  <= 3'h0;
      gpio_in_out <= 3'h0;
    end else begin
      pin_out     <= pin_d;
      pin_oe_out  <= oe_d;
      gpio_in_out <= pin_s2_reg;
    end
  end

  // ****************************************
  // link clock side
  // ****************************************
  rbf_pkg::rbf_tx_t tx_st_reg;
  rbf_pkg::rbf_rx_t rx_st_reg;
  logic [1:0]  rst_s_reg, ack_s_reg, rxp_s_reg, frm_s_reg, aak_s_reg;
  logic [2:0]  go_s_reg;
  logic        rst_l, go_pend_reg, tx_mode_reg, rx_mode_reg, byte_rdy, ack_go;
  logic [63:0] tx_sh_reg, rx_sh_reg, win;
  logic [6:0]  tx_cnt_reg, rx_cnt_reg;
  logic [8:0]  tx_idx_reg, rx_idx_reg, nidx;
  logic [7:0]  tx_len_reg, nbyte, rb, rx_hi_reg;
  logic [15:0] tx_crc_reg, seed_l_reg, rx_crc_reg, rx_zcrc_reg;
  logic        need_pl, tx_last, rx_fin, rx_match, sop_hit, dsss_hit;

  // reset, level and toggle synchronisers
  always_ff @(posedge clk_link_in) begin
    rst_s_reg <= {rst_s_reg[0], reset_in};
    go_s_reg  <= {go_s_reg[1:0], go_tog_reg};
    ack_s_reg <= {ack_s_reg[0], ack_tog_reg};
    rxp_s_reg <= {rxp_s_reg[0], link_rx_in};
    frm_s_reg <= {frm_s_reg[0], framing_en_in};
    aak_s_reg <= {aak_s_reg[0], auto_ack_en_in};
  end
  assign rst_l = rst_s_reg[1];

  // next transmit byte selection
  always_comb begin
    nidx     = (tx_st_reg == rbf_pkg::TX_SOP) ? 9'h0 : tx_idx_reg + 9'h1;
    need_pl  = (nidx != 9'h0) && (nidx <= {1'h0, tx_len_reg});
    tx_last  = nidx > ({1'h0, tx_len_reg} + 9'h2);
    byte_rdy = (ack_s_reg[1] == req_tog_reg);
    if (nidx == 9'h0) nbyte = tx_len_reg; // R15
    else if (need_pl) nbyte = hd_data_reg;
    else if (nidx == {1'h0, tx_len_reg} + 9'h1) nbyte = tx_crc_reg[15:8];
    else nbyte = tx_crc_reg[7:0];
  end

  assign link_tx_out    = tx_sh_reg[63];
  assign link_tx_en_out = (tx_st_reg != rbf_pkg::TX_IDLE);

  // transmit sequencer; an underrun holds the line low until the byte arrives
  always_ff @(posedge clk_link_in) begin
    if (rst_l) begin
      tx_st_reg <= rbf_pkg::TX_IDLE;
      {tx_sh_reg, tx_cnt_reg, tx_idx_reg, tx_len_reg} <= '0;
      {tx_crc_reg, seed_l_reg, tx_mode_reg, go_pend_reg} <= '0;
      {req_tog_reg, txd_tog_reg} <= 2'h0;
    end else begin
      if (go_s_reg[2] != go_s_reg[1]) go_pend_reg <= 1'h1;
      case (tx_st_reg)
        rbf_pkg::TX_IDLE: begin
          if (ack_go || go_pend_reg) begin
            tx_st_reg   <= rbf_pkg::TX_SOP;
            tx_cnt_reg  <= rbf_pkg::CNT_SOP; // R14
            tx_len_reg  <= ack_go ? 8'h0 : go_len_reg; // R05
            tx_mode_reg <= ack_go ? rx_mode_reg : go_mode_reg;
            tx_sh_reg   <= {rbf_pkg::SOP_CODE, (ack_go ? rx_mode_reg : go_mode_reg)
                            ? ~rbf_pkg::SOP_CODE : rbf_pkg::SOP_CODE}; // R04
            tx_crc_reg  <= ack_go ? seed_l_reg : go_seed_reg;
            if (!ack_go) begin
              seed_l_reg  <= go_seed_reg;
              go_pend_reg <= 1'h0;
              if (go_len_reg != 8'h0) req_tog_reg <= ~req_tog_reg;
            end
          end
        end
        rbf_pkg::TX_SOP, rbf_pkg::TX_BODY: begin
          if (tx_cnt_reg != 7'h0) begin
            tx_cnt_reg <= tx_cnt_reg - 7'h1;
            tx_sh_reg  <= {tx_sh_reg[62:0], 1'h0}; // R01
          end else if (tx_last) begin
            tx_st_reg   <= rbf_pkg::TX_IDLE; // R06
            tx_sh_reg   <= 64'h0;
            txd_tog_reg <= ~txd_tog_reg;
          end else if (need_pl && !byte_rdy) begin
            tx_sh_reg <= 64'h0;
          end else begin
            tx_st_reg  <= rbf_pkg::TX_BODY;
            tx_idx_reg <= nidx;
            tx_sh_reg  <= tx_mode_reg ? {rbf_pkg::spread(nbyte), 32'h0} // R02 R08 R03
                                      : {nbyte, 56'h0};
            tx_cnt_reg <= tx_mode_reg ? rbf_pkg::CNT_DSSS : rbf_pkg::CNT_GFSK;
            if (need_pl) tx_crc_reg <= rbf_pkg::crc_upd(tx_crc_reg, nbyte); // R17
            if (need_pl && nidx < {1'h0, tx_len_reg}) req_tog_reg <= ~req_tog_reg;
          end
        end
        default: tx_st_reg <= rbf_pkg::TX_IDLE;
      endcase
    end
  end

  // receive window includes the chip arriving now
  always_comb begin
    win      = {rx_sh_reg[62:0], rxp_s_reg[1]};
    sop_hit  = (win[63:32] == rbf_pkg::SOP_CODE) && ((win[31:0] == rbf_pkg::SOP_CODE)
               || (win[31:0] == ~rbf_pkg::SOP_CODE));
    dsss_hit = (win[31:0] == ~rbf_pkg::SOP_CODE);
    rb       = rx_mode_reg ? rbf_pkg::despread(win[31:0]) : win[7:0];
    rx_fin   = (rx_st_reg == rbf_pkg::RX_BODY) && (rx_cnt_reg == 7'h0)
               && (rx_idx_reg == {1'h0, rx_len_reg} + 9'h2);
    rx_match = ({rx_hi_reg, rb} == rx_crc_reg) || ({rx_hi_reg, rb} == rx_zcrc_reg);
    ack_go   = rx_fin && rx_match && aak_s_reg[1];
  end

  // receive deframer; hunts only while framing is on and transmit is idle
  always_ff @(posedge clk_link_in) begin
    if (rst_l) begin
      rx_st_reg <= rbf_pkg::RX_HUNT;
      {rx_sh_reg, rx_cnt_reg, rx_idx_reg, rx_len_reg, rx_hi_reg} <= '0;
      {rx_crc_reg, rx_zcrc_reg, rx_byte_reg, rx_mode_reg} <= '0;
      {rx_tog_reg, rdn_tog_reg, rx_ok_reg} <= 3'h0;
    end else begin
      rx_sh_reg <= win;
      case (rx_st_reg)
        rbf_pkg::RX_HUNT: begin
          if (sop_hit && frm_s_reg[1] && tx_st_reg == rbf_pkg::TX_IDLE) begin
            rx_st_reg   <= rbf_pkg::RX_BODY; // R04
            rx_mode_reg <= dsss_hit;
            rx_cnt_reg  <= dsss_hit ? rbf_pkg::CNT_DSSS : rbf_pkg::CNT_GFSK;
            rx_idx_reg  <= 9'h0;
            rx_crc_reg  <= seed_l_reg;
            rx_zcrc_reg <= 16'h0;
          end
        end
        rbf_pkg::RX_BODY: begin
          if (rx_cnt_reg != 7'h0) begin
            rx_cnt_reg <= rx_cnt_reg - 7'h1;
          end else begin
            rx_cnt_reg <= rx_mode_reg ? rbf_pkg::CNT_DSSS : rbf_pkg::CNT_GFSK;
            rx_idx_reg <= rx_idx_reg + 9'h1;
            if (rx_idx_reg == 9'h0) begin
              rx_len_reg <= rb; // R15
            end else if (rx_idx_reg <= {1'h0, rx_len_reg}) begin
              rx_byte_reg <= rb;
              rx_tog_reg  <= ~rx_tog_reg;
              rx_crc_reg  <= rbf_pkg::crc_upd(rx_crc_reg, rb); // R06
              rx_zcrc_reg <= rbf_pkg::crc_upd(rx_zcrc_reg, rb);
            end else if (!rx_fin) begin
              rx_hi_reg <= rb;
            end else begin
              rx_st_reg   <= rbf_pkg::RX_HUNT; // R16
              rx_ok_reg   <= rx_match;
              rdn_tog_reg <= ~rdn_tog_reg;
              rx_sh_reg   <= 64'h0;
            end
          end
        end
        default: rx_st_reg <= rbf_pkg::RX_HUNT;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_chan;
    @(posedge clk_sys_in) disable iff (reset_in) chan_out < rbf_pkg::CHAN_CNT;
  endproperty
  a_chan: assert property (p_chan) else $error("channel out of range"); // R07
  property p_irq;
    @(posedge clk_sys_in) disable iff (reset_in)
      !irq_gpio_in |=> pin_out[0] == $past(irq_event_in ^ irq_low_in);
  endproperty
  a_irq: assert property (p_irq) else $error("irq polarity wrong"); // R11
  property p_miso;
    @(posedge clk_sys_in) disable iff (reset_in)
      !spi_4wire_in |=> pin_out[1] == $past(gpio_out_in[1]);
  endproperty
  a_miso: assert property (p_miso) else $error("miso not gpio in 3-wire"); // R12
  property p_gfsk;
    @(posedge clk_link_in) disable iff (rst_l)
      tx_st_reg == rbf_pkg::TX_BODY && tx_cnt_reg == 7'h0 && !tx_mode_reg
      ##1 tx_st_reg == rbf_pkg::TX_BODY && $changed(tx_idx_reg) |-> tx_cnt_reg == 7'h7;
  endproperty
  a_gfsk: assert property (p_gfsk) else $error("gfsk byte not 8 bits"); // R01
  property p_dsss;
    @(posedge clk_link_in) disable iff (rst_l)
      $changed(tx_idx_reg) && tx_mode_reg && tx_st_reg == rbf_pkg::TX_BODY
      |-> tx_cnt_reg == 7'h1f;
  endproperty
  a_dsss: assert property (p_dsss) else $error("dsss symbol not 32 chips"); // R02
  property p_sop;
    @(posedge clk_link_in) disable iff (rst_l)
      $rose(tx_st_reg == rbf_pkg::TX_SOP) |-> ##64 tx_st_reg == rbf_pkg::TX_BODY;
  endproperty
  a_sop: assert property (p_sop) else $error("sop not 64 chips"); // R14
  property p_eop;
    @(posedge clk_link_in) disable iff (rst_l) rx_fin |=> rx_st_reg == rbf_pkg::RX_HUNT;
  endproperty
  a_eop: assert property (p_eop) else $error("no eop after crc"); // R16
  property p_ack;
    @(posedge clk_link_in) disable iff (rst_l)
      ack_go && tx_st_reg == rbf_pkg::TX_IDLE |=> tx_st_reg == rbf_pkg::TX_SOP
      && tx_len_reg == 8'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("auto ack missing"); // R05
  property p_mode;
    @(posedge clk_link_in) disable iff (rst_l)
      tx_st_reg == rbf_pkg::TX_BODY ##1 tx_st_reg == rbf_pkg::TX_BODY |-> $stable(tx_mode_reg);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed in body"); // R03
  c_rx_ok: cover property (@(posedge clk_link_in) rx_fin && rx_match);
  c_dsss: cover property (@(posedge clk_link_in) tx_mode_reg && tx_st_reg == rbf_pkg::TX_BODY);
  c_full: cover property (@(posedge clk_sys_in) tx_valid_in && !tx_ready_out);
endmodule // rbf_framer

// ---- tb/rbf_link_peer.sv ----
`timescale 1ns/10ps

// ****
// far-side radio peer on the link
// ****
module rbf_link_peer (
  // link
  input  wire logic clk_link_in,
  input  wire logic link_tx_in,
  input  wire logic link_tx_en_in,
  output logic      link_rx_out
);
  logic chips_q[$];
  logic sending;

  initial begin
    link_rx_out = 1'h0;
    sending = 1'h0;
  end

  // released line wiggles so a stale level is never read as data
  always @(posedge clk_link_in) if (!sending) link_rx_out <= ~link_rx_out;

  // everything the device puts on air, taken mid-chip
  always @(negedge clk_link_in) if (link_tx_en_in === 1'h1) chips_q.push_back(link_tx_in);

  // one byte: one chip per bit, or a whole 32-chip symbol
  task automatic put_byte(input logic dsss, input logic [7:0] b);
    for (int i = (dsss ? 31 : 7); i >= 0; i--) begin
      @(posedge clk_link_in);
      link_rx_out <= dsss ? (rbf_pkg::PN_CODE[i] ^ b[i / 4]) : b[i];
    end
  endtask

  // sop pair, length, payload, crc in one rate
  task automatic send(input logic dsss, input logic [7:0] d[$], input logic [15:0] crc);
    logic [31:0] s2;
    s2 = dsss ? ~rbf_pkg::SOP_CODE : rbf_pkg::SOP_CODE;
    sending = 1'h1;
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk_link_in);
      link_rx_out <= (i > 31) ? rbf_pkg::SOP_CODE[i - 32] : s2[i];
    end
    put_byte(dsss, 8'(d.size()));
    foreach (d[k]) put_byte(dsss, d[k]);
    put_byte(dsss, crc[15:8]);
    put_byte(dsss, crc[7:0]);
    @(negedge clk_link_in);
    sending = 1'h0;
  endtask
endmodule // rbf_link_peer

// ---- tb/tb_rbf_framer.sv ----
`timescale 1ns/10ps

// ****
// framer bench
// ****
module tb_rbf_framer;
  logic        clk_sys_in, clk_link_in, reset_in, mode_dsss_in, framing_en_in;
  logic        auto_ack_en_in, crc_zero_seed_in, tx_valid_in, tx_go_in, tx_ready_out;
  logic        tx_busy_out, tx_done_out, rx_valid_out, rx_done_out, rx_crc_ok_out;
  logic        link_rx_in, link_tx_out, link_tx_en_out, irq_event_in, irq_low_in;
  logic        irq_gpio_in, spi_4wire_in, miso_data_in, radio_port_select_n_in;
  logic        clk_out_gpio_in, ok_seen, pa;
  logic [15:0] crc_seed_in;
  logic [6:0]  chan_in, chan_out;
  logic [7:0]  tx_data_in, tx_len_in, rx_data_out, rx_len_out, len_seen;
  logic [2:0]  gpio_out_in, gpio_oe_in, pin_in, pin_out, pin_oe_out, gpio_in_out;
  logic        exp_q[$];
  logic [7:0]  got_q[$], dq[$], none_q[$];
  int          bad_count, samples_checked, done_cnt;

  rbf_framer #(.FIFO_D(16)) dut (.clk_sys_in, .clk_link_in, .reset_in, .mode_dsss_in,
    .framing_en_in, .auto_ack_en_in, .crc_seed_in, .crc_zero_seed_in, .chan_in, .chan_out,
    .tx_data_in, .tx_valid_in, .tx_ready_out, .tx_len_in, .tx_go_in, .tx_busy_out,
    .tx_done_out, .rx_data_out, .rx_valid_out, .rx_done_out, .rx_crc_ok_out, .rx_len_out,
    .link_rx_in, .link_tx_out, .link_tx_en_out, .irq_event_in, .irq_low_in, .irq_gpio_in,
    .spi_4wire_in, .miso_data_in, .radio_port_select_n_in, .clk_out_gpio_in, .gpio_out_in,
    .gpio_oe_in, .pin_in, .pin_out, .pin_oe_out, .gpio_in_out);
  rbf_link_peer peer (.clk_link_in, .link_tx_in(link_tx_out), .link_tx_en_in(link_tx_en_out),
    .link_rx_out(link_rx_in));

  // link clock offset so the two domains never line up
  initial begin
    clk_sys_in = 1'h0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    clk_link_in = 1'h0;
    #1.3;
    forever #6 clk_link_in = ~clk_link_in;
  end

  // receive side monitor, pulses last one cycle
  always @(negedge clk_sys_in) begin
    if (rx_valid_out === 1'h1) got_q.push_back(rx_data_out);
    if (rx_done_out === 1'h1) begin
      done_cnt++;
      ok_seen = rx_crc_ok_out;
      len_seen = rx_len_out;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // own crc model, msb first
  function automatic logic [15:0] ref_crc(input logic [15:0] s, input logic [7:0] d[$]);
    logic [15:0] c;
    c = s;
    foreach (d[k]) for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'h0} ^ ((c[15] ^ d[k][i]) ? rbf_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction

  // expected air chips of a whole frame
  task automatic exp_frame(input logic dsss, input logic [7:0] d[$], input logic [15:0] crc);
    logic [7:0] all[$];
    all = {8'(d.size()), d, crc[15:8], crc[7:0]};
    exp_q.delete();
    for (int i = 63; i >= 0; i--)
      exp_q.push_back((i > 31) ? rbf_pkg::SOP_CODE[i - 32] : (rbf_pkg::SOP_CODE[i] ^ dsss));
    foreach (all[k]) for (int i = (dsss ? 31 : 7); i >= 0; i--)
      exp_q.push_back(dsss ? (rbf_pkg::PN_CODE[i] ^ all[k][i / 4]) : all[k][i]);
  endtask

  task automatic chk_chips(input string what);
    int n = 0;
    if (peer.chips_q.size() != exp_q.size()) n = 1000;
    else foreach (exp_q[i]) if (peer.chips_q[i] !== exp_q[i]) n++;
    chk(what, 32'h0, 32'(n));
  endtask

  // a hang here ends the run
  task automatic wait_tx();
    int i = 0;
    while (tx_done_out !== 1'h1) begin
      @(negedge clk_sys_in);
      i++;
      if (i > 5000) begin
        chk("tx_done_wait", 32'h1, 32'h0);
        summarize();
      end
    end
  endtask

  // fill fifo, go, then compare what went on air
  task automatic tx_pkt(input logic dsss, input logic [15:0] seed, input logic zs,
                        input logic [7:0] d[$]);
    peer.chips_q.delete();
    mode_dsss_in = dsss;
    crc_seed_in = seed;
    crc_zero_seed_in = zs;
    tx_len_in = 8'(d.size());
    foreach (d[k]) begin
      tx_data_in = d[k];
      tx_valid_in = 1'h1;
      @(negedge clk_sys_in);
    end
    chk("tx_ready", 32'(d.size() < 16), {31'h0, tx_ready_out});
    tx_valid_in = 1'h0;
    tx_go_in = 1'h1;
    @(negedge clk_sys_in);
    tx_go_in = 1'h0;
    @(negedge clk_sys_in);
    chk("tx_busy", 32'h1, {31'h0, tx_busy_out});
    wait_tx();
    chk("tx_idle", 32'h0, {31'h0, tx_busy_out});
    exp_frame(dsss, d, zs ? ref_crc(16'h0000, d) : ref_crc(seed, d));
    chk_chips("tx_chips");
  endtask

  task automatic rx_pkt(input logic dsss, input logic [7:0] d[$], input logic [15:0] crc);
    got_q.delete();
    done_cnt = 0;
    peer.chips_q.delete();
    peer.send(dsss, d, crc);
    for (int i = 0; i < 60 && done_cnt == 0; i++) @(negedge clk_sys_in);
  endtask

  task automatic chk_rx(input logic [7:0] d[$], input logic ok);
    chk("rx_done", 32'h1, 32'(done_cnt));
    chk("rx_crc_ok", {31'h0, ok}, {31'h0, ok_seen});
    chk("rx_len", 32'(d.size()), {24'h0, len_seen});
    chk("rx_count", 32'(d.size()), 32'(got_q.size()));
    foreach (d[k]) chk("rx_byte", {24'h0, d[k]}, {24'h0, got_q[k]});
  endtask

  initial begin
    {mode_dsss_in, framing_en_in, auto_ack_en_in, crc_zero_seed_in, tx_valid_in} = 5'h00;
    {tx_go_in, irq_event_in, irq_low_in, irq_gpio_in, spi_4wire_in} = 5'h00;
    {miso_data_in, clk_out_gpio_in, radio_port_select_n_in, reset_in} = 4'h3;
    {crc_seed_in, chan_in, tx_data_in, tx_len_in} = 39'h0;
    {gpio_out_in, gpio_oe_in, pin_in} = 9'h000;
    bad_count = 0;
    samples_checked = 0;
    done_cnt = 0;
    repeat (20) @(negedge clk_sys_in);
    reset_in = 1'h0;
    repeat (3) @(posedge clk_link_in);
    @(negedge clk_sys_in);
    chk("chan_reset", 32'h0, {25'h0, chan_out});
    chan_in = 7'h61;
    repeat (2) @(negedge clk_sys_in);
    chk("chan_top", 32'h61, {25'h0, chan_out});
    chan_in = 7'h62;
    repeat (2) @(negedge clk_sys_in);
    chk("chan_over", 32'h61, {25'h0, chan_out});
    // pins: irq active low, miso data, clock out running
    {irq_event_in, irq_low_in, spi_4wire_in, miso_data_in, radio_port_select_n_in} = 5'h1e;
    {clk_out_gpio_in, pin_in} = 4'h5;
    repeat (6) @(negedge clk_sys_in);
    chk("pins_a", 32'h2, {30'h0, pin_out[1:0]});
    chk("oe_a", 32'h7, {29'h0, pin_oe_out});
    chk("gpio_in", 32'h5, {29'h0, gpio_in_out});
    pa = pin_out[2];
    @(negedge clk_sys_in);
    chk("clk_pin", 32'h1, {31'h0, pa ^ pin_out[2]});
    // irq active high, miso released, clock pin as gpio
    {irq_low_in, radio_port_select_n_in, clk_out_gpio_in, gpio_out_in, gpio_oe_in} = 9'h0e4;
    repeat (6) @(negedge clk_sys_in);
    chk("pins_b", 32'h3, {30'h0, pin_out[2], pin_out[0]});
    chk("oe_b", 32'h5, {29'h0, pin_oe_out});
    // three-wire: miso and irq both as gpio
    {irq_gpio_in, spi_4wire_in, gpio_out_in, gpio_oe_in} = 8'h92;
    repeat (6) @(negedge clk_sys_in);
    chk("pins_c", 32'h1, {31'h0, pin_out[1]});
    chk("oe_c", 32'h2, {29'h0, pin_oe_out});
    dq = {8'ha5, 8'h3c};
    tx_pkt(1'h1, 16'hbeef, 1'h1, dq);
    dq.delete();
    for (int k = 0; k < 16; k++) dq.push_back(8'(k * 29 + 129)); // fills the fifo
    tx_pkt(1'h0, 16'h1234, 1'h0, dq);
    framing_en_in = 1'h1;
    rx_pkt(1'h0, dq, ref_crc(16'h1234, dq));
    chk_rx(dq, 1'h1);
    // dsss packet with zero-seed crc while tx mode says gfsk, ack expected
    auto_ack_en_in = 1'h1;
    dq = {8'h5a};
    rx_pkt(1'h1, dq, ref_crc(16'h0000, dq));
    chk_rx(dq, 1'h1);
    wait_tx();
    exp_frame(1'h1, none_q, 16'h1234);
    chk_chips("ack_chips");
    // corrupted crc: flagged and never acked
    dq = {8'h11, 8'h22, 8'h33};
    rx_pkt(1'h0, dq, ~ref_crc(16'h1234, dq));
    chk_rx(dq, 1'h0);
    repeat (100) @(negedge clk_sys_in);
    chk("no_ack", 32'h0, 32'(peer.chips_q.size()));
    framing_en_in = 1'h0;
    rx_pkt(1'h0, dq, ref_crc(16'h1234, dq));
    chk("rx_ignored", 32'h0, 32'(done_cnt));
    summarize();
  end
endmodule // tb_rbf_framer
